// File: verilog/scs_defines.vh
// Constants for the successive-approximation conversion sequencer
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH
`define SCS_NBITS 16
`define SCS_MIDSCALE 16'h8000
`define SCS_ZERO_CODE 16'h0000
`define SCS_FULL_CODE 16'hffff
`define SCS_CLK_HZ 10000000
`define SCS_RATE_SPS 500000
`define SCS_CYCLE_BUDGET (`SCS_CLK_HZ / `SCS_RATE_SPS)
`define SCS_OPEN_CYCLES 2'h1
`define SCS_SETTLE_CYCLES 2'h1
`endif

// File: verilog/scs_sar_register.v
// Successive-approximation trial register and bit weight shifter
`timescale 1ns/1ns
`include "scs_defines.vh"
module scs_sar_register (
   // Clock and reset
   input wire clock,
   input wire resetn,
   // Control
   input wire load,
   input wire step,
   input wire compHigh,
   // State
   output reg [15:0] trial,
   output reg [15:0] weight,
   output wire lastStep
);
   assign lastStep = weight[0];
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         trial <= `SCS_ZERO_CODE;
         weight <= `SCS_ZERO_CODE;
      end else if (load) begin
         trial <= `SCS_MIDSCALE;
         weight <= `SCS_MIDSCALE;
      end else if (step) begin
         // Keep or drop the trial bit, then try the next lower one
         trial <= (compHigh ? trial : (trial & ~weight)) | (weight >> 1);
         weight <= weight >> 1;
      end
   end
endmodule // scs_sar_register

// File: verilog/scs_conversion_sequencer.v
// Conversion sequencer of a 16-bit charge-redistribution SAR converter
// Function
// - A rising convert_start edge ends acquisition and starts a conversion
// - In acquisition, comparator side grounded and arrays on analog inputs
// - Sampling switches open first, then arrays move to ground
// - Sixteen bits resolved MSB first, one comparator decision per bit
// - After the search, return to acquisition, latch code, signal busy end
// - Internal clock alone advances the search, serial clock unused
// - Output code belongs to the sample of the same start edge
// - Conversions up to 500 kSPS, powered down between conversions
// - Output code is 16-bit straight binary
// - Over-range input saturates at all ones
// - Under-range input saturates at all zeros
// - Serial data input level at start edge selects chain or select mode
// - Result shifted out per serial clock while selected, outside block
`timescale 1ns/1ns
`include "scs_defines.vh"
module scs_conversion_sequencer (
   // Clock and reset
   input wire clock,
   input wire resetn,
   // Host side
   input wire convertStart,
   input wire serialDataIn,
   // Comparator and range detect
   input wire compHigh,
   input wire overRange,
   input wire underRange,
   // Switch controls
   output reg sampleSwitchPos,
   output reg sampleSwitchNeg,
   output reg arrayOnInputs,
   output reg [15:0] arrayToRef,
   output reg powerUp,
   // Result
   output reg [15:0] resultCode,
   output reg resultValid,
   output reg busy,
   output reg chainMode
);
   // Sequencer states
   localparam IDLE = 3'h0;
   localparam OPEN = 3'h1;
   localparam HOLD = 3'h2;
   localparam SRCH = 3'h3;
   localparam DONE = 3'h4;

   // Sequencer state and captured range flags
   reg [2:0] state;
   reg [2:0] next_state;
   reg startPrev;
   reg over;
   reg under;

   // Search register and decision paths
   wire startEdge;
   wire load;
   wire step;
   wire finish;
   wire lastStep;
   wire [15:0] trial;
   wire [15:0] weight;
   wire [15:0] decided;
   wire [15:0] nextTrial;

   // Trial code with the bit under test kept or dropped
   function [15:0] keepOrDrop;
      input [15:0] tryCode;
      input [15:0] tryWeight;
      input keep;
      begin
         if (keep) begin
            keepOrDrop = tryCode;
         end else begin
            keepOrDrop = tryCode & ~tryWeight;
         end
      end
   endfunction

   // Saturate the code when the held sample was out of range
   function [15:0] clampCode;
      input [15:0] code;
      input high;
      input low;
      begin
         if (high) begin
            clampCode = `SCS_FULL_CODE;
         end else if (low) begin
            clampCode = `SCS_ZERO_CODE;
         end else begin
            clampCode = code;
         end
      end
   endfunction

   assign startEdge = convertStart & ~startPrev;
   assign load = (state == HOLD);
   assign step = (state == SRCH);
   assign finish = step & lastStep;
   assign decided = keepOrDrop(trial, weight, compHigh);
   assign nextTrial = decided | (weight >> 1);

   scs_sar_register sar (
      .clock(clock),
      .resetn(resetn),
      .load(load),
      .step(step),
      .compHigh(compHigh),
      .trial(trial),
      .weight(weight),
      .lastStep(lastStep)
   );

   // Next state of the sequencer
   always @* begin
      next_state = state;
      case (state)
         IDLE: if (startEdge) next_state = OPEN;
         OPEN: next_state = HOLD;
         HOLD: next_state = SRCH;
         SRCH: if (lastStep) next_state = DONE;
         DONE: next_state = IDLE;
         default: next_state = IDLE;
      endcase
   end

   // State and start edge history
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state <= IDLE;
         startPrev <= 1'b0;
      end else begin
         state <= next_state;
         startPrev <= convertStart;
      end
   end

   // Busy and power follow the conversion
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
         powerUp <= 1'b0;
      end else if (state == IDLE && startEdge) begin
         busy <= 1'b1;
         powerUp <= 1'b1;
      end else if (state == DONE) begin
         busy <= 1'b0;
         powerUp <= 1'b0;
      end
   end

   // Interface mode taken on the start edge
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         chainMode <= 1'b0;
      end else if (state == IDLE && startEdge) begin
         chainMode <= ~serialDataIn;
      end
   end

   // Switches open before the arrays leave the inputs
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sampleSwitchPos <= 1'b1;
         sampleSwitchNeg <= 1'b1;
      end else if (state == IDLE && startEdge) begin
         sampleSwitchPos <= 1'b0;
         sampleSwitchNeg <= 1'b0;
      end else if (state == DONE) begin
         sampleSwitchPos <= 1'b1;
         sampleSwitchNeg <= 1'b1;
      end
   end

   // Arrays move to ground once the switches are open
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         arrayOnInputs <= 1'b1;
      end else if (state == OPEN) begin
         arrayOnInputs <= 1'b0;
      end else if (state == DONE) begin
         arrayOnInputs <= 1'b1;
      end
   end

   // Range flags taken while the sample is held
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         over <= 1'b0;
         under <= 1'b0;
      end else if (state == HOLD) begin
         over <= overRange;
         under <= underRange;
      end
   end

   // Trial pattern on the reference side of the arrays
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         arrayToRef <= `SCS_ZERO_CODE;
      end else if (state == HOLD) begin
         arrayToRef <= `SCS_MIDSCALE;
      end else if (finish) begin
         arrayToRef <= `SCS_ZERO_CODE;
      end else if (step) begin
         arrayToRef <= nextTrial;
      end
   end

   // One-cycle strobe at the end of the search
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         resultValid <= 1'b0;
      end else begin
         resultValid <= finish;
      end
   end

   // Code stands until the next search ends, for the serial shifter
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         resultCode <= `SCS_ZERO_CODE;
      end else if (finish) begin
         // Code from this conversion only, no pipeline
         resultCode <= clampCode(decided, over, under);
      end
   end
endmodule // scs_conversion_sequencer

// File: verification/scs_chk.sv
// Assertion checker for the conversion sequencer
`timescale 1ns/1ns
module scs_chk (
   // Watched ports
   input wire clock,
   input wire resetn,
   input wire busy,
   input wire resultValid,
   input wire sampleSwitchPos,
   input wire sampleSwitchNeg,
   input wire arrayOnInputs,
   input wire powerUp,
   input wire [15:0] arrayToRef,
   input wire [15:0] resultCode
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   property p_go; $rose(busy) |-> !sampleSwitchPos && powerUp; endproperty
   a_go: assert property (p_go) else $error("go");
   property p_ord; !arrayOnInputs |-> !sampleSwitchPos; endproperty
   a_ord: assert property (p_ord) else $error("ord");
   property p_acq;
      !busy |-> sampleSwitchPos && arrayOnInputs && !powerUp;
   endproperty
   a_acq: assert property (p_acq) else $error("acq");
   property p_msb; $rose(busy) |-> ##2 arrayToRef == 16'h8000; endproperty
   a_msb: assert property (p_msb) else $error("msb");
   property p_val; $rose(busy) |-> ##18 resultValid; endproperty
   a_val: assert property (p_val) else $error("val");
   property p_end; resultValid |=> !busy && !powerUp; endproperty
   a_end: assert property (p_end) else $error("end");
   property p_hold; busy && !resultValid |-> $stable(resultCode); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_len; $rose(busy) |-> busy[*8] ##12 !busy; endproperty
   a_len: assert property (p_len) else $error("len");
   property p_pair; sampleSwitchNeg == sampleSwitchPos; endproperty
   a_pair: assert property (p_pair) else $error("pair");
   property p_keep; !resultValid |-> $stable(resultCode); endproperty
   a_keep: assert property (p_keep) else $error("keep");
   c_top: cover property (resultValid && resultCode == 16'hffff);
   c_bot: cover property (resultValid && resultCode == 16'h0000);
   c_mid: cover property (resultValid && resultCode == 16'h8000);
endmodule // scs_chk
bind scs_conversion_sequencer scs_chk u_chk (
   .clock(clock),
   .resetn(resetn),
   .busy(busy),
   .resultValid(resultValid),
   .sampleSwitchPos(sampleSwitchPos),
   .sampleSwitchNeg(sampleSwitchNeg),
   .arrayOnInputs(arrayOnInputs),
   .powerUp(powerUp),
   .arrayToRef(arrayToRef),
   .resultCode(resultCode)
);

// File: verification/scs_front_model.sv
// Analog input and comparator model
`timescale 1ns/1ns
module scs_front_model (
   // Host side
   input wire [15:0] level,
   input wire ovr,
   input wire und,
   input wire convertStart,
   // Converter side
   input wire busy,
   input wire [15:0] arrayToRef,
   output wire compHigh,
   output reg overRange,
   output reg underRange
);
   reg [15:0] held;
   initial {held, overRange, underRange} = 18'h0;
   always @(posedge convertStart) if (!busy) begin
      held <= level;
      overRange <= ovr;
      underRange <= und;
   end
   assign compHigh = arrayToRef <= held;
endmodule // scs_front_model

// File: verification/scs_conversion_sequencer_bench.sv
// Testbench for the conversion sequencer
`timescale 1ns/1ns
module scs_conversion_sequencer_bench;
   reg clock = 1'b0;
   reg resetn = 1'b0;
   reg convertStart = 1'b0;
   reg serialDataIn = 1'b0;
   reg [15:0] level = 16'h0;
   reg ovr = 1'b0;
   reg und = 1'b0;
   reg [31:0] r;
   wire compHigh, overRange, underRange, sampleSwitchPos, sampleSwitchNeg;
   wire arrayOnInputs, powerUp, resultValid, busy, chainMode;
   wire [15:0] arrayToRef, resultCode;
   integer errors = 0, checksDone = 0, seed = 91, i, n;
   always #50 clock = ~clock;
   scs_conversion_sequencer dut (
      .clock(clock),
      .resetn(resetn),
      .convertStart(convertStart),
      .serialDataIn(serialDataIn),
      .compHigh(compHigh),
      .overRange(overRange),
      .underRange(underRange),
      .sampleSwitchPos(sampleSwitchPos),
      .sampleSwitchNeg(sampleSwitchNeg),
      .arrayOnInputs(arrayOnInputs),
      .arrayToRef(arrayToRef),
      .powerUp(powerUp),
      .resultCode(resultCode),
      .resultValid(resultValid),
      .busy(busy),
      .chainMode(chainMode)
   );
   scs_front_model fe (
      .level(level),
      .ovr(ovr),
      .und(und),
      .convertStart(convertStart),
      .busy(busy),
      .arrayToRef(arrayToRef),
      .compHigh(compHigh),
      .overRange(overRange),
      .underRange(underRange)
   );
   function [15:0] want(input [15:0] v, input o, input u);
      want = o ? 16'hffff : (u ? 16'h0000 : v);
   endfunction
   task check(input [15:0] seen, input [15:0] exp);
      begin
         checksDone = checksDone + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
         end
      end
   endtask
   task wrapUp;
      begin
         $display("checks %0d errors %0d", checksDone, errors);
         if (errors == 0 && checksDone > 0) begin
            $display("No errors found");
         end else begin
            $display("Errors were found");
         end
         $finish;
      end
   endtask
   task conv(input [15:0] v, input o, input u);
      begin
         @(posedge clock);
         {level, ovr, und, serialDataIn} <= {v, o, u, v[0]};
         @(posedge clock);
         convertStart <= 1'b1;
         repeat (4) @(posedge clock);
         convertStart <= 1'b0;
         level <= ~v;
         @(posedge clock);
         convertStart <= 1'b1;
         n = 0;
         @(negedge clock);
         while (resultValid !== 1'b1 && n < 40) begin
            @(negedge clock);
            n = n + 1;
         end
         check({15'h0, resultValid}, 16'h0001);
         check(n[15:0], 16'h000e);
         check(resultCode, want(v, o, u));
         check({15'h0, chainMode}, {15'h0, ~v[0]});
         repeat (3) @(posedge clock);
         convertStart <= 1'b0;
      end
   endtask
   initial begin
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      conv(16'h0000, 1'b0, 1'b0);
      conv(16'h8000, 1'b0, 1'b0);
      conv(16'hffff, 1'b0, 1'b0);
      conv(16'h7fff, 1'b1, 1'b1);
      conv(16'h0001, 1'b0, 1'b1);
      conv(16'h4321, 1'b1, 1'b0);
      for (i = 0; i < 12; i = i + 1) begin
         r = $random(seed);
         conv(r[15:0], r[16] & r[17], r[18] & r[19]);
      end
      wrapUp;
   end
   initial begin
      #100000;
      errors = errors + 1;
      wrapUp;
   end
endmodule // scs_conversion_sequencer_bench
